// file: src/gsp_params.svh
`ifndef GSP_PARAMS_SVH
`define GSP_PARAMS_SVH
`define GSP_NUM_OUTPUTS      4
`define GSP_ADDR_MAX         5'h1E
`define GSP_PP_DEFAULT_LIMIT 5'h07
`define GSP_RQS_BIT          6
`define GSP_CH_SPACE         8'h20
`define GSP_CH_COMMA         8'h2C
`define GSP_CH_LF            8'h0A
`define GSP_CH_CR            8'h0D
`define GSP_CH_SEMI          8'h3B
`define GSP_CH_LOW_A         8'h61
`define GSP_CH_LOW_Z         8'h7A
`define GSP_CASE_BIT         8'h20
`endif

// file: src/gsp_pkg.sv
package gsp_pkg;
    typedef enum logic [1:0] {
        GSP_CH_OTHER,
        GSP_CH_SEP,
        GSP_CH_TERM
    } gsp_char_kind_type;

    typedef enum logic [1:0] {
        GSP_TX_IDLE,
        GSP_TX_CR,
        GSP_TX_LF
    } gsp_tx_state_type;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } gsp_byte_type;

    typedef struct packed {
        logic       configured;
        logic       sense;
        logic [2:0] line;
    } gsp_ppconf_type;
endpackage

// file: src/gsp_poll_port.sv
// Contract
// - support SH1 AH1 T6 L4 SR1 RL1 PP1 DC1
// - request service on fault, error, power-on
// - request holds until serial poll clears it
// - clear-supply command withdraws pending request
// - remote blocks panel keys except local key
// - local key refused while remote commands accepted; code refuses it while cmd_busy or in lockout
// - lockout from bus blocks all panel programming
// - remote/local change keeps programmed settings
// - parallel poll presents status bit six
// - parallel poll leaves request bit intact
// - default poll line equals address, 0-7
// - configured poll uses given sense and line
// - serial poll drives eight-bit status byte
// - device clear acts like clear-supply command
// - address 0 to 30, else range error
// - power-on request when enabled, poll clears
// - address and power-on enable kept non-volatile
// - header letters case-insensitive
// - space/comma separate, LF/semicolon terminate
// - addressed indicator when listener or talker
// - responses end CR then LF with EOI
// - commands execute in arrival order
`timescale 1ns/1ps
`include "gsp_params.svh"
module gsp_poll_port #(
    parameter int NOUT = `GSP_NUM_OUTPUTS
) (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // request causes, from pins
    input  wire logic [NOUT-1:0]       fault_in,
    input  wire logic                  prog_error,
    input  wire logic                  power_up_event,
    // bus state messages, from the bus transceiver
    input  wire logic                  listen_addressed,
    input  wire logic                  talk_addressed,
    input  wire logic                  remote_enable,
    input  wire logic                  local_lockout_msg,
    input  wire logic                  go_to_local_msg,
    input  wire logic                  serial_poll_done,
    input  wire logic                  serial_poll_active,
    input  wire logic                  parallel_poll_active,
    input  wire logic                  device_clear_msg,
    input  wire gsp_pkg::gsp_ppconf_type pp_conf,
    // command path
    input  wire logic                  clear_supply_command,
    input  wire logic                  cmd_busy,
    input  wire gsp_pkg::gsp_byte_type rx_byte,
    input  wire logic                  resp_end,
    // settings store
    input  wire logic                  addr_wr,
    input  wire logic [4:0]            addr_wr_data,
    input  wire logic                  pon_wr,
    input  wire logic                  pon_wr_data,
    input  wire logic [4:0]            nv_addr,
    input  wire logic                  nv_pon,
    input  wire logic                  nv_load,
    // front panel
    input  wire logic                  return_to_front_panel_key,
    input  wire logic                  panel_key,
    // status and poll outputs
    output logic [7:0]                 status_byte,
    output logic [7:0]                 dio_out,
    output logic [7:0]                 dio_oe,
    output logic                       srq_out,
    output logic                       srq_indicator,
    output logic                       addr_indicator,
    output logic                       remote_state,
    output logic                       panel_key_accept,
    output logic                       range_error,
    output logic [4:0]                 bus_address,
    output logic                       power_on_request_enable,
    // lexer, command start and response ending outputs
    output gsp_pkg::gsp_byte_type      lex_byte,
    output gsp_pkg::gsp_char_kind_type lex_kind,
    output logic                       cmd_start_ok,
    output gsp_pkg::gsp_byte_type      tx_byte,
    output logic                       tx_eoi
);
    // bit five of the status byte carries the error flag
    if (NOUT < 1 || NOUT > 5) begin : g_nout_check
        $error("NOUT must be 1..5");
    end

    // two-flop synchronisers for pin inputs
    logic [NOUT+1:0] s1_r;
    logic [NOUT+1:0] s2_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_r <= '0;
            s2_r <= '0;
        end else begin
            s1_r <= {power_up_event, prog_error, fault_in};
            s2_r <= s1_r;
        end
    end
    logic [NOUT-1:0] fault_s;
    logic            err_s;
    logic            pup_s;
    logic [NOUT-1:0] fault_q_r;
    logic            err_q_r;
    logic            pup_q_r;
    assign fault_s = s2_r[NOUT-1:0];
    assign err_s   = s2_r[NOUT];
    assign pup_s   = s2_r[NOUT+1];

    // service request state
    logic req_r;
    logic req_nxt;
    logic pon_req_r;
    logic pon_req_nxt;
    logic req_event;
    logic clr_any;
    logic loaded_r;
    assign clr_any = clear_supply_command | device_clear_msg;
    assign req_event = |(fault_s & ~fault_q_r) | (err_s & ~err_q_r)
                     | (pon_req_nxt & ~pon_req_r);

    always_comb begin
        pon_req_nxt = pon_req_r;
        if ((power_on_request_enable && pup_s && !pup_q_r) ||
            (nv_load && !loaded_r && nv_pon))
            pon_req_nxt = 1'b1;
        else if (serial_poll_done || clr_any)
            pon_req_nxt = 1'b0;
        req_nxt = req_r;
        // hold until serial poll or clear, set wins
        if (req_event)
            req_nxt = 1'b1;
        else if (serial_poll_done || clr_any)
            req_nxt = 1'b0;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_r     <= 1'b0;
            pon_req_r <= 1'b0;
            fault_q_r <= '0;
            err_q_r   <= 1'b0;
            pup_q_r   <= 1'b0;
        end else begin
            req_r     <= req_nxt;
            pon_req_r <= pon_req_nxt;
            fault_q_r <= fault_s;
            err_q_r   <= err_s;
            pup_q_r   <= pup_s;
        end
    end

    assign srq_out       = req_r;
    assign srq_indicator = req_r;

    // status byte: causes low, request bit six
    logic [7:0] sb_r;
    logic [7:0] sb_nxt;
    always_comb begin
        sb_nxt = 8'h00;
        sb_nxt[NOUT-1:0] = fault_s;
        sb_nxt[5] = err_s;
        sb_nxt[`GSP_RQS_BIT] = req_nxt;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) sb_r <= 8'h00;
        else     sb_r <= sb_nxt;
    end
    assign status_byte = sb_r;

    // poll data drive
    logic [7:0] dout_r;
    logic [7:0] dout_nxt;
    logic [7:0] doe_r;
    logic [7:0] doe_nxt;
    logic [2:0] pp_line;
    logic       pp_bit;
    logic       pp_en;
    always_comb begin
        dout_nxt = 8'h00;
        doe_nxt  = 8'h00;
        if (pp_conf.configured) begin
            pp_line = pp_conf.line;
            pp_bit  = pp_conf.sense;
            pp_en   = req_r;
        end else begin
            pp_line = bus_address[2:0];
            pp_bit  = 1'b1;
            pp_en   = req_r && (bus_address <= `GSP_PP_DEFAULT_LIMIT);
        end
        if (serial_poll_active && talk_addressed) begin
            dout_nxt = sb_r;
            doe_nxt  = 8'hFF;
        end else if (parallel_poll_active && pp_en) begin
            dout_nxt[pp_line] = pp_bit;
            doe_nxt[pp_line]  = 1'b1;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            dout_r <= 8'h00;
            doe_r  <= 8'h00;
        end else begin
            dout_r <= dout_nxt;
            doe_r  <= doe_nxt;
        end
    end
    assign dio_out = dout_r;
    assign dio_oe  = doe_r;

    // remote/local and lockout
    logic rem_r;
    logic rem_nxt;
    logic llo_r;
    logic llo_nxt;
    always_comb begin
        rem_nxt = rem_r;
        llo_nxt = llo_r;
        if (local_lockout_msg)
            llo_nxt = 1'b1;
        if (!remote_enable)
            llo_nxt = 1'b0;
        if (listen_addressed && remote_enable)
            rem_nxt = 1'b1;
        else if (go_to_local_msg || !remote_enable)
            rem_nxt = 1'b0;
        // local refused while busy or locked
        else if (return_to_front_panel_key && !cmd_busy && !llo_r)
            rem_nxt = 1'b0;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rem_r <= 1'b0;
            llo_r <= 1'b0;
        end else begin
            rem_r <= rem_nxt;
            llo_r <= llo_nxt;
        end
    end
    assign remote_state = rem_r;
    assign panel_key_accept = panel_key && !rem_r && !llo_r;
    // mode change touches no setting store
    assign addr_indicator = listen_addressed | talk_addressed;

    // non-volatile copies of address and power-on enable
    logic [4:0] addr_r;
    logic [4:0] addr_nxt;
    logic       pon_r;
    logic       pon_nxt;
    logic       rerr_r;
    logic       rerr_nxt;
    logic       loaded_nxt;
    always_comb begin
        addr_nxt = addr_r;
        pon_nxt  = pon_r;
        rerr_nxt = 1'b0;
        loaded_nxt = loaded_r | nv_load;
        if (nv_load && !loaded_r) begin
            addr_nxt = nv_addr;
            pon_nxt  = nv_pon;
        end
        if (addr_wr) begin
            if (addr_wr_data <= `GSP_ADDR_MAX)
                addr_nxt = addr_wr_data;
            else
                rerr_nxt = 1'b1;
        end
        if (pon_wr)
            pon_nxt = pon_wr_data;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            addr_r   <= 5'h00;
            pon_r    <= 1'b0;
            rerr_r   <= 1'b0;
            loaded_r <= 1'b0;
        end else begin
            addr_r   <= addr_nxt;
            pon_r    <= pon_nxt;
            rerr_r   <= rerr_nxt;
            loaded_r <= loaded_nxt;
        end
    end
    assign bus_address             = addr_r;
    assign power_on_request_enable = pon_r;
    assign range_error             = rerr_r;

    // lexer
    gsp_pkg::gsp_byte_type      lb_r;
    gsp_pkg::gsp_byte_type      lb_nxt;
    gsp_pkg::gsp_char_kind_type lk_r;
    gsp_pkg::gsp_char_kind_type lk_nxt;
    always_comb begin
        lb_nxt = rx_byte;
        lk_nxt = gsp_pkg::GSP_CH_OTHER;
        if (rx_byte.data >= `GSP_CH_LOW_A && rx_byte.data <= `GSP_CH_LOW_Z)
            lb_nxt.data = rx_byte.data & ~`GSP_CASE_BIT;
        if (rx_byte.data == `GSP_CH_SPACE || rx_byte.data == `GSP_CH_COMMA)
            lk_nxt = gsp_pkg::GSP_CH_SEP;
        else if (rx_byte.data == `GSP_CH_LF || rx_byte.data == `GSP_CH_SEMI)
            lk_nxt = gsp_pkg::GSP_CH_TERM;
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lb_r <= '0;
            lk_r <= gsp_pkg::GSP_CH_OTHER;
        end else begin
            lb_r <= lb_nxt;
            lk_r <= lk_nxt;
        end
    end
    assign lex_byte = lb_r;
    assign lex_kind = lk_r;
    assign cmd_start_ok = !cmd_busy;

    // response ending
    gsp_pkg::gsp_tx_state_type tx_r;
    gsp_pkg::gsp_tx_state_type tx_nxt;
    always_comb begin
        case (tx_r)
            gsp_pkg::GSP_TX_IDLE: tx_nxt = resp_end ? gsp_pkg::GSP_TX_CR
                                                    : gsp_pkg::GSP_TX_IDLE;
            gsp_pkg::GSP_TX_CR:   tx_nxt = gsp_pkg::GSP_TX_LF;
            default:              tx_nxt = gsp_pkg::GSP_TX_IDLE;
        endcase
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) tx_r <= gsp_pkg::GSP_TX_IDLE;
        else     tx_r <= tx_nxt;
    end
    assign tx_byte.valid = (tx_r != gsp_pkg::GSP_TX_IDLE);
    assign tx_byte.data  = (tx_r == gsp_pkg::GSP_TX_LF) ? `GSP_CH_LF
                                                         : `GSP_CH_CR;
    assign tx_eoi        = (tx_r == gsp_pkg::GSP_TX_LF);

    // handshakes live in transceiver; poll, clear, RL here

    AST_POLL_CLEARS: assert property (@(posedge clk) disable iff (rst)
        serial_poll_done && !req_event |=> !srq_out)
        else $error("poll did not clear request");
    AST_CLR_CLEARS: assert property (@(posedge clk) disable iff (rst)
        clr_any && !req_event |=> !srq_out)
        else $error("clear did not withdraw request");
    AST_FAULT_SETS: assert property (@(posedge clk) disable iff (rst)
        req_event |=> srq_out)
        else $error("event did not raise request");
    AST_PP_KEEPS: assert property (@(posedge clk) disable iff (rst)
        srq_out && parallel_poll_active && !serial_poll_done && !clr_any
        |=> srq_out)
        else $error("parallel poll cleared request");
    AST_RQS_BIT: assert property (@(posedge clk) disable iff (rst)
        status_byte[`GSP_RQS_BIT] == srq_out)
        else $error("status bit six differs from request");
    AST_ADDR_RANGE: assert property (@(posedge clk) disable iff (rst)
        addr_wr && addr_wr_data > `GSP_ADDR_MAX |=> range_error
        && bus_address == $past(bus_address))
        else $error("bad address not refused");
    AST_PANEL_BLOCK: assert property (@(posedge clk) disable iff (rst)
        remote_state |-> !panel_key_accept)
        else $error("panel key accepted in remote");
    AST_CRLF: assert property (@(posedge clk) disable iff (rst)
        resp_end && tx_r == gsp_pkg::GSP_TX_IDLE |=>
        tx_byte.data == `GSP_CH_CR ##1 tx_eoi && tx_byte.data == `GSP_CH_LF)
        else $error("response ending wrong");
    AST_SPOLL_DRIVE: assert property (@(posedge clk) disable iff (rst)
        serial_poll_active && talk_addressed |=> dio_oe == 8'hFF)
        else $error("status byte not driven");

    COV_SPOLL: cover property (@(posedge clk) srq_out ##1 serial_poll_done);
    COV_PPOLL: cover property (@(posedge clk)
        parallel_poll_active && |dio_oe);
    COV_LLO:   cover property (@(posedge clk) llo_r && remote_state);
endmodule

// file: dv/gsp_ctrl_model.sv
`timescale 1ns/1ps
module gsp_ctrl_model (
    // clock
    input  wire logic               clk,
    // data lines seen from the bus
    input  wire logic [7:0]         dio_out,
    input  wire logic [7:0]         dio_oe,
    // bus state messages
    output logic                    listen_addressed,
    output logic                    talk_addressed,
    output logic                    remote_enable,
    output logic                    local_lockout_msg,
    output logic                    go_to_local_msg,
    output logic                    serial_poll_done,
    output logic                    serial_poll_active,
    output logic                    parallel_poll_active,
    output logic                    device_clear_msg,
    output gsp_pkg::gsp_ppconf_type pp_conf
);
    initial begin
        {listen_addressed, talk_addressed, remote_enable} = 3'h0;
        {local_lockout_msg, go_to_local_msg, device_clear_msg} = 3'h0;
        {serial_poll_done, serial_poll_active} = 2'h0;
        parallel_poll_active = 1'b0;
        pp_conf = '0;
    end
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic set_bus(input logic ren, input logic lad, input logic tad);
        {remote_enable, listen_addressed, talk_addressed} = {ren, lad, tad};
        step(2);
    endtask
    // 0 lockout, 1 go to local, 2 device clear; one-cycle message
    task automatic msg(input int k);
        local_lockout_msg = (k == 0);
        go_to_local_msg = (k == 1);
        device_clear_msg = (k == 2);
        step(1);
        {local_lockout_msg, go_to_local_msg, device_clear_msg} = 3'h0;
        step(1);
    endtask
    task automatic spoll(output logic [7:0] sb);
        serial_poll_active = 1'b1;
        talk_addressed = 1'b1;
        step(2);
        sb = dio_out;
        serial_poll_active = 1'b0;
        talk_addressed = 1'b0;
        serial_poll_done = 1'b1;
        step(1);
        serial_poll_done = 1'b0;
    endtask
    task automatic ppoll(input gsp_pkg::gsp_ppconf_type c,
                         output logic [7:0] d, output logic [7:0] oe);
        pp_conf = c;
        parallel_poll_active = 1'b1;
        step(2);
        d = dio_out;
        oe = dio_oe;
        parallel_poll_active = 1'b0;
        step(2);
    endtask
endmodule

// file: dv/gsp_poll_port_tb.sv
`timescale 1ns/1ps
module gsp_poll_port_tb;
    logic                       clk, rst, prog_error, power_up_event;
    logic [3:0]                 fault_in;
    logic                       clear_supply_command, cmd_busy, resp_end;
    logic                       addr_wr, pon_wr, pon_wr_data, nv_pon, nv_load;
    logic [4:0]                 addr_wr_data, nv_addr, bus_address;
    logic                       return_to_front_panel_key, panel_key;
    gsp_pkg::gsp_byte_type      rx_byte, lex_byte, tx_byte;
    logic [7:0]                 status_byte, dio_out, dio_oe, sb, d, oe;
    logic                       srq_out, srq_indicator, addr_indicator;
    logic                       remote_state, panel_key_accept, range_error;
    logic                       power_on_request_enable, cmd_start_ok, tx_eoi;
    gsp_pkg::gsp_char_kind_type lex_kind;
    logic                       listen_addressed, talk_addressed;
    logic                       remote_enable, local_lockout_msg;
    logic                       go_to_local_msg, serial_poll_done;
    logic                       serial_poll_active, parallel_poll_active;
    logic                       device_clear_msg;
    gsp_pkg::gsp_ppconf_type    pp_conf;
    int                         n_errors, num_checks;
    logic [7:0] ci [7] = '{8'h61, 8'h7A, 8'h51, 8'h20, 8'h2C, 8'h0A, 8'h3B};
    logic [7:0] co [7] = '{8'h41, 8'h5A, 8'h51, 8'h20, 8'h2C, 8'h0A, 8'h3B};
    logic [1:0] ck [7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};

    gsp_poll_port i_gsp_poll_port (.*);
    gsp_ctrl_model i_gsp_ctrl_model (.*);

    always #2 clk = ~clk;

    task automatic tick(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string nm, input logic [8:0] e,
                       input logic [8:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wait_srq();
        repeat (10) if (srq_out !== 1'b1) tick();
    endtask
    task automatic wr_addr(input logic [4:0] v);
        {addr_wr, addr_wr_data} = {1'b1, v};
        tick();
        addr_wr = 1'b0;
        chk("range_error", {8'h00, v > 5'h1E}, {8'h00, range_error});
        tick();
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        #40000;
        n_errors++;
        final_report();
    end

    initial begin
        {clk, rst, fault_in, prog_error, power_up_event} = 8'h40;
        {clear_supply_command, cmd_busy, resp_end, addr_wr} = 4'h0;
        {pon_wr, pon_wr_data, nv_pon, nv_load, panel_key} = 5'h00;
        {addr_wr_data, nv_addr, return_to_front_panel_key} = 11'h000;
        rx_byte = '0;
        tick(4);
        rst = 1'b0;
        {nv_addr, nv_load} = {5'h05, 1'b1};
        tick();
        nv_load = 1'b0;
        tick();
        chk("bus_address", 9'h005, bus_address);
        chk("srq_out", 9'h000, srq_out);
        $display("test reset done");

        fault_in = 4'h4;
        wait_srq();
        chk("srq_out", 9'h003, {srq_indicator, srq_out});
        chk("status_byte", 9'h044, status_byte);
        i_gsp_ctrl_model.spoll(sb);
        chk("poll byte", 9'h044, sb);
        chk("srq cleared", 9'h000, {srq_indicator, srq_out});
        chk("status_byte", 9'h004, status_byte);
        fault_in = 4'h0;
        $display("test serial poll done");

        prog_error = 1'b1;
        wait_srq();
        chk("error bit", 9'h060, status_byte & 8'h60);
        clear_supply_command = 1'b1;
        tick();
        clear_supply_command = 1'b0;
        tick();
        chk("srq after clear", 9'h000, srq_out);
        prog_error = 1'b0;
        tick(3);
        prog_error = 1'b1;
        wait_srq();
        i_gsp_ctrl_model.msg(2);
        chk("srq after dcl", 9'h000, srq_out);
        prog_error = 1'b0;
        $display("test clear done");

        wr_addr(5'h03);
        fault_in = 4'h1;
        wait_srq();
        i_gsp_ctrl_model.ppoll('0, d, oe);
        chk("pp default", {1'b0, oe}, {1'b0, d & oe});
        chk("pp line", 9'h008, oe);
        chk("srq after pp", 9'h001, srq_out);
        i_gsp_ctrl_model.ppoll({1'b1, 1'b0, 3'h5}, d, oe);
        chk("pp sense 0", 9'h002, {oe[5], d[5]});
        i_gsp_ctrl_model.ppoll({1'b1, 1'b1, 3'h0}, d, oe);
        chk("pp sense 1", 9'h003, {oe[0], d[0]});
        wr_addr(5'h08);
        i_gsp_ctrl_model.ppoll('0, d, oe);
        chk("pp addr 8", 9'h000, oe);
        i_gsp_ctrl_model.spoll(sb);
        fault_in = 4'h0;
        $display("test parallel poll done");

        wr_addr(5'h1E);
        wr_addr(5'h1F);
        chk("bus_address", 9'h01E, bus_address);
        $display("test address done");

        i_gsp_ctrl_model.set_bus(1'b1, 1'b1, 1'b0);
        chk("remote", 9'h003, {remote_state, addr_indicator});
        i_gsp_ctrl_model.set_bus(1'b1, 1'b0, 1'b0);
        {panel_key, cmd_busy, return_to_front_panel_key} = 3'h7;
        tick(2);
        chk("key in remote", 9'h000, panel_key_accept);
        chk("start ok", 9'h000, cmd_start_ok);
        chk("local refused", 9'h001, remote_state);
        {cmd_busy, return_to_front_panel_key} = 2'h0;
        i_gsp_ctrl_model.set_bus(1'b1, 1'b0, 1'b1);
        chk("talk addr", 9'h001, addr_indicator);
        i_gsp_ctrl_model.set_bus(1'b1, 1'b0, 1'b0);
        return_to_front_panel_key = 1'b1;
        tick(2);
        return_to_front_panel_key = 1'b0;
        tick();
        chk("local", 9'h001, {remote_state, panel_key_accept});
        chk("kept address", 9'h01E, bus_address);
        i_gsp_ctrl_model.set_bus(1'b1, 1'b1, 1'b0);
        i_gsp_ctrl_model.msg(0);
        i_gsp_ctrl_model.set_bus(1'b1, 1'b0, 1'b0);
        return_to_front_panel_key = 1'b1;
        tick(2);
        return_to_front_panel_key = 1'b0;
        chk("lockout", 9'h002, {remote_state, panel_key_accept});
        i_gsp_ctrl_model.set_bus(1'b0, 1'b0, 1'b0);
        panel_key = 1'b0;
        $display("test remote local done");

        for (int i = 0; i < 7; i++) begin
            rx_byte = {1'b1, ci[i]};
            tick();
            chk("lex_byte", {1'b1, co[i]}, lex_byte);
            chk("lex_kind", {7'h00, ck[i]}, {7'h00, lex_kind});
        end
        rx_byte = '0;
        resp_end = 1'b1;
        tick();
        resp_end = 1'b0;
        chk("tx cr", {1'b1, 8'h0D}, tx_byte);
        chk("tx eoi cr", 9'h000, tx_eoi);
        tick();
        chk("tx lf", {1'b1, 8'h0A}, tx_byte);
        chk("tx eoi lf", 9'h001, tx_eoi);
        $display("test lexer done");

        {pon_wr, pon_wr_data} = 2'h3;
        tick();
        pon_wr = 1'b0;
        tick();
        chk("pon enable", 9'h001, power_on_request_enable);
        power_up_event = 1'b1;
        wait_srq();
        chk("pon srq", 9'h001, srq_out);
        i_gsp_ctrl_model.spoll(sb);
        chk("pon srq cleared", 9'h000, srq_out);
        power_up_event = 1'b0;
        $display("test power on done");

        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        {nv_addr, nv_pon, nv_load} = {5'h07, 1'b1, 1'b1};
        tick();
        nv_load = 1'b0;
        wait_srq();
        chk("stored pon srq", 9'h001, srq_out);
        chk("stored address", 9'h007, bus_address);
        $display("test reset again done");
        final_report();
    end
endmodule
